// File: cpu_core_model.sv
// Behavioural CPU core that ends instruction cycles and enters offered traps.
`timescale 1ns/100ps
module cpu_core_model #(
    parameter int ACK_WAIT = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic trap_valid,
    output logic cycle_end,
    output logic entry_ack
);
    // ------------------------------------------------------------------
    // Instruction cycles and trap entry
    // ------------------------------------------------------------------
    logic [1:0] phase_q;
    logic [5:0] wait_q;
    // The core is slow on purpose so the bench can inspect a pending trap.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= 2'h0;
            wait_q <= 6'h00;
            cycle_end <= 1'b0;
            entry_ack <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            cycle_end <= (phase_q == 2'h3);
            entry_ack <= trap_valid && !entry_ack && (wait_q == 6'(ACK_WAIT));
            wait_q <= (trap_valid && !entry_ack) ? wait_q + 6'h01 : 6'h00;
        end
    end
endmodule

// File: tb_trap_and_interrupt_arbiter.sv
// Self-checking bench of the trap and interrupt arbiter over AHB-Lite.
`timescale 1ns/100ps
`include "trap_arbiter_defines.vh"
module tb_trap_and_interrupt_arbiter;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, cycle_end, entry_ack, trap_valid, restart, event_xfer;
    logic [15:0] node_request = 16'h0000;
    logic [1:0] legacy_irq = 2'b00;
    logic [8:0] trap_cause = 9'h000;
    logic sw_reset = 1'b0;
    logic wdt_overflow = 1'b0;
    logic [6:0] trap_number;
    logic [8:0] trap_vector;
    logic [1:0] trap_priority;
    logic [3:0] entry_level;
    logic [2:0] event_channel;
    logic [31:0] rdata;
    int err_count = 0;
    int tests_run = 0;
    // Clock of 8 ns.
    initial begin
        forever #4 hclk = ~hclk;
    end
    trap_and_interrupt_arbiter u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout), .node_request(node_request),
        .legacy_bus_irq0(legacy_irq[0]), .legacy_bus_irq1(legacy_irq[1]),
        .software_reset_instruction(sw_reset), .watchdog_overflow(wdt_overflow), .nmi_pin(trap_cause[0]),
        .stack_overflow_event(trap_cause[1]), .stack_underflow_event(trap_cause[2]),
        .debug_event(trap_cause[3]), .undefined_opcode_event(trap_cause[4]),
        .protected_instruction_event(trap_cause[5]), .illegal_word_operand_event(trap_cause[6]),
        .illegal_instruction_access_event(trap_cause[7]), .illegal_external_bus_event(trap_cause[8]),
        .cycle_end(cycle_end), .entry_ack(entry_ack), .trap_valid(trap_valid), .trap_number(trap_number),
        .trap_vector(trap_vector), .trap_priority(trap_priority), .entry_level(entry_level),
        .restart(restart), .event_xfer(event_xfer), .event_channel(event_channel));
    cpu_core_model #(.ACK_WAIT(20)) u_cpu (.hclk(hclk), .hresetn(hresetn), .trap_valid(trap_valid),
        .cycle_end(cycle_end), .entry_ack(entry_ack));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One single word transfer; the address phase is held until hready.
    task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
        bus(1'b1, addr, wd, rdata);
    endtask
    task automatic rd(input string name, input logic [11:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0000_0000, rdata);
        chk(name, rdata, exp);
        chk("hresp", hresp, 32'h0000_0000);
    endtask
    // Bounded wait for a trap offer, or for a channel transfer when xfer is set.
    task automatic wait_hi(input bit xfer);
        int n;
        n = 0;
        while (((xfer ? event_xfer : trap_valid) !== 1'b1) && n < 100) begin
            @(posedge hclk);
            n++;
        end
        if (n == 100) chk("wait_timeout", 32'h0000_0001, 32'h0000_0000);
    endtask
    task automatic expect_trap(input logic [6:0] num, input logic [1:0] prio);
        wait_hi(1'b0);
        chk("trap_number", trap_number, num);
        chk("trap_vector", trap_vector, {num, 2'b00});
        chk("trap_priority", trap_priority, prio);
    endtask
    task automatic wait_clear();
        int n;
        n = 0;
        while (trap_valid !== 1'b0 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        chk("trap_entered", trap_valid, 32'h0000_0000);
    endtask
    task automatic quiet();
        repeat (16) @(posedge hclk);
        chk("no_trap", trap_valid, 32'h0000_0000);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    // Nodes: 3 and 4 share level 5, node 5 sits higher but disabled.
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("ctrl_reset", 12'h008, 32'h0000_0000);
        rd("psw_reset", `OFS_PSW, 32'h0000_0000);
        wr(12'h008, 32'hFFFF_FFFF);
        rd("ctrl_word", 12'h008, 32'h0000_00FF);
        wr(12'h008, 32'h0000_0000);
        wr(12'h1F0, 32'hFFFF_FFFF);
        rd("unmapped", 12'h1F0, 32'h0000_0000);
        wr(12'h00C, 32'h0000_00D5);
        wr(12'h010, 32'h0000_00D6);
        wr(12'h014, 32'h0000_00A4);
        quiet();
        wr(`OFS_PSW, 32'h0000_0800);
        expect_trap(7'h44, 2'h0);
        chk("entry_level", entry_level, 32'h0000_0005);
        wait_clear();
        rd("ctrl_served", 12'h010, 32'h0000_0056);
        rd("psw_entry", `OFS_PSW, 32'h0000_5800);
        quiet();
        wr(12'h014, 32'h0000_00E4);
        expect_trap(7'h45, 2'h0);
        wait_clear();
        wr(`OFS_PSW, 32'h0000_0800);
        expect_trap(7'h43, 2'h0);
        wait_clear();
        // Class A then class B traps, each with its own flag.
        for (int i = 0; i < 9; i++) begin
            trap_cause[i] <= 1'b1;
            @(posedge hclk);
            trap_cause[i] <= 1'b0;
            expect_trap(i < 4 ? 7'(2 + 2 * i) : 7'h0A, i < 4 ? 2'h2 : 2'h1);
            rd("trap_flags", `OFS_TRAP_FLAGS, 32'h0000_0001 << i);
            wr(`OFS_TRAP_FLAGS, 32'h0000_0001 << i);
            wait_clear();
        end
        // Level 15 group 2 with a count of one: transfer, then a normal interrupt.
        wr(`OFS_PSW, 32'h0000_0800);
        wr(`OFS_CHAN_COUNT_BASE + 12'h018, 32'h0000_0001);
        wr(12'h018, 32'h0000_00FE);
        wait_hi(1'b1);
        chk("event_channel", event_channel, 32'h0000_0006);
        expect_trap(7'h46, 2'h0);
        rd("chan_count", `OFS_CHAN_COUNT_BASE + 12'h018, 32'h0000_0000);
        wait_clear();
        // Legacy lines on nodes 0 and 1, a plain request line on node 8.
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_PSW, 32'h0000_0800);
            wr(i == 2 ? 12'h020 : 12'(4 * i), 32'h0000_004C);
            if (i == 2) node_request[8] <= 1'b1;
            else legacy_irq[i] <= 1'b1;
            expect_trap(i == 2 ? 7'h48 : 7'(7'h40 + i), 2'h0);
            node_request[8] <= 1'b0;
            legacy_irq <= 2'b00;
            wait_clear();
            // The line was still high at the clear, so the new request won.
            rd("ctrl_set_wins", i == 2 ? 12'h020 : 12'(4 * i), 32'h0000_00CC);
            wr(i == 2 ? 12'h020 : 12'(4 * i), 32'h0000_0000);
        end
        wr(`OFS_PSW, 32'h0000_3800);
        wr(`OFS_SW_TRAP, 32'h0000_007F);
        expect_trap(7'h7F, 2'h0);
        chk("sw_entry_level", entry_level, 32'h0000_0003);
        rd("vector_reg", `OFS_VECTOR, 32'h0000_01FC);
        wait_clear();
        rd("psw_sw_trap", `OFS_PSW, 32'h0000_3800);
        // Software reset, then watchdog overflow.
        for (int i = 0; i < 2; i++) begin
            if (i == 0) sw_reset <= 1'b1;
            else wdt_overflow <= 1'b1;
            @(posedge hclk);
            sw_reset <= 1'b0;
            wdt_overflow <= 1'b0;
            #1;
            chk("restart", restart, 32'h0000_0001);
            chk("reset_priority", trap_priority, 32'h0000_0003);
            repeat (40) @(posedge hclk);
        end
        stop_test();
    end
    // The tests need some 700 cycles; give up at 20000.
    initial begin
        #160000;
        err_count++;
        stop_test();
    end
endmodule
bind trap_and_interrupt_arbiter trap_arbiter_props u_props (.hclk(hclk), .hresetn(hresetn),
    .software_reset_instruction(software_reset_instruction), .watchdog_overflow(watchdog_overflow),
    .entry_ack(entry_ack), .trap_valid(trap_valid), .trap_number(trap_number), .trap_vector(trap_vector),
    .trap_priority(trap_priority), .restart(restart));

// File: trap_and_interrupt_arbiter.v
// Trap and interrupt arbiter with AHB-Lite register access.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "trap_arbiter_defines.vh"

module trap_and_interrupt_arbiter (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire hready,
    input wire [`NUM_NODES-1:0] node_request,
    input wire legacy_bus_irq0,
    input wire legacy_bus_irq1,
    input wire software_reset_instruction,
    input wire watchdog_overflow,
    input wire nmi_pin,
    input wire stack_overflow_event,
    input wire stack_underflow_event,
    input wire debug_event,
    input wire undefined_opcode_event,
    input wire protected_instruction_event,
    input wire illegal_word_operand_event,
    input wire illegal_instruction_access_event,
    input wire illegal_external_bus_event,
    input wire cycle_end,
    input wire entry_ack,
    output reg trap_valid,
    output reg [6:0] trap_number,
    output reg [8:0] trap_vector,
    output reg [1:0] trap_priority,
    output reg [3:0] entry_level,
    output reg restart,
    output reg event_xfer,
    output reg [2:0] event_channel
);

    // ------------------------------------------------------------------------
    // Pin synchronisers for the external request lines.
    // ------------------------------------------------------------------------
    reg [`NUM_NODES+2:0] pin_s1_q;
    reg [`NUM_NODES+2:0] pin_s2_q;
    reg nmi_s2_last_q;

    // Two flops before any logic reads a pin; the first is read only here.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= {(`NUM_NODES+3){1'b0}};
            pin_s2_q <= {(`NUM_NODES+3){1'b0}};
            nmi_s2_last_q <= 1'b0;
        end else begin
            pin_s1_q <= {nmi_pin, legacy_bus_irq1, legacy_bus_irq0, node_request};
            pin_s2_q <= pin_s1_q;
            nmi_s2_last_q <= pin_s2_q[`NUM_NODES+2];
        end
    end

    wire [`NUM_NODES-1:0] src_req;
    // Legacy lines only share existing nodes, they own no register.
    assign src_req = pin_s2_q[`NUM_NODES-1:0]
        | ({{(`NUM_NODES-1){1'b0}}, pin_s2_q[`NUM_NODES]} << `USB_TX_NODE)
        | ({{(`NUM_NODES-1){1'b0}}, pin_s2_q[`NUM_NODES+1]} << `EXT_EVENT_NODE);
    wire nmi_rise;
    assign nmi_rise = pin_s2_q[`NUM_NODES+2] & ~nmi_s2_last_q;

    // ------------------------------------------------------------------------
    // AHB-Lite slave: one-cycle address capture, zero wait states.
    // ------------------------------------------------------------------------
    reg wr_pend_q;
    reg [11:0] wr_addr_q;
    wire acc;
    assign acc = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= acc & hwrite;
            wr_addr_q <= haddr;
        end
    end

    wire wr_ctl;
    assign wr_ctl = wr_pend_q && (wr_addr_q[11:6] == 6'h00);
    wire wr_cnt;
    assign wr_cnt = wr_pend_q && (wr_addr_q[11:5] == `OFS_CHAN_COUNT_BASE >> 5);

    // ------------------------------------------------------------------------
    // Processor status word upper byte: level and global enable.
    // ------------------------------------------------------------------------
    reg [3:0] cpu_level_q;
    reg ien_q;
    reg [7:0] chan_count_q [0:7];
    reg [7:0] ctl_q [0:`NUM_NODES-1];

    // ------------------------------------------------------------------------
    // Arbitration: highest level, then highest group, over enabled requests.
    // ------------------------------------------------------------------------
    reg [5:0] best_key;
    reg [3:0] best_idx;
    reg best_ok;
    integer i;
    always @* begin
        best_key = 6'h00;
        best_idx = 4'h0;
        best_ok = 1'b0;
        for (i = 0; i < `NUM_NODES; i = i + 1) begin
            // Key is {level, group}, so level F and group 3 win.
            if (ctl_q[i][`CTL_REQ_BIT] && ctl_q[i][`CTL_EN_BIT]
                && (!best_ok || ctl_q[i][`CTL_LVL_HI:0] > best_key)) begin
                best_key = ctl_q[i][`CTL_LVL_HI:0];
                best_idx = i[3:0];
                best_ok = 1'b1;
            end
        end
    end

    wire [3:0] best_lvl;
    assign best_lvl = best_key[5:2];
    // Strictly above CPU level and globally enabled.
    wire win;
    assign win = best_ok && ien_q && (best_lvl > cpu_level_q);
    // Top two levels go to event channels unless that channel count is zero.
    wire [2:0] win_chan;
    assign win_chan = {best_lvl[0], best_key[1:0]};
    wire chan_lvl;
    assign chan_lvl = (best_lvl == `CHAN_LVL_HI) || (best_lvl == `CHAN_LVL_LO);
    wire use_chan;
    assign use_chan = win && chan_lvl && (chan_count_q[win_chan] != 8'h00);
    // Decision is taken once per instruction cycle, at its end.
    wire take_chan;
    assign take_chan = cycle_end && use_chan && !trap_valid;
    wire take_irq;
    // A pending hardware trap holds interrupts back, so no request flag is cleared for a lost entry.
    assign take_irq = cycle_end && win && !use_chan && !trap_valid && !(|tflag_q);

    // ------------------------------------------------------------------------
    // Hardware trap flags, sticky; set wins over a software clear.
    // ------------------------------------------------------------------------
    reg [8:0] tflag_q;
    wire [8:0] tset;
    assign tset = {illegal_external_bus_event, illegal_instruction_access_event,
                   illegal_word_operand_event, protected_instruction_event,
                   undefined_opcode_event, debug_event, stack_underflow_event,
                   stack_overflow_event, nmi_rise};
    reg sw_trap_q;
    reg [6:0] sw_trap_num_q;
    // Marks an offered node interrupt; only such an entry may raise the CPU level.
    reg irq_entry_q;

    // ------------------------------------------------------------------------
    // Per-node control registers, one per node.
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NUM_NODES; g = g + 1) begin : node
            wire wsel;
            assign wsel = wr_ctl && (wr_addr_q[5:2] == g);
            wire hw_clr;
            assign hw_clr = (take_irq && best_idx == g)
                || (take_chan && best_idx == g && chan_count_q[win_chan] != 8'h01);
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ctl_q[g] <= `CTL_RESET;
                end else begin
                    // Software writes the whole low byte; upper byte discarded.
                    if (wsel) begin
                        ctl_q[g] <= hwdata[7:0];
                    end else if (hw_clr) begin
                        ctl_q[g][`CTL_REQ_BIT] <= 1'b0;
                    end
                    // A new request always wins over any clear.
                    if (src_req[g]) begin
                        ctl_q[g][`CTL_REQ_BIT] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Status word, channel counts, trap flags and software trap request.
    integer k;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_level_q <= `PSW_LVL_RESET;
            ien_q <= 1'b0;
            tflag_q <= 9'h000;
            sw_trap_q <= 1'b0;
            sw_trap_num_q <= 7'h00;
            for (k = 0; k < 8; k = k + 1) begin
                chan_count_q[k] <= 8'h00;
            end
        end else begin
            if (wr_pend_q && wr_addr_q == `OFS_PSW) begin
                cpu_level_q <= hwdata[`PSW_LVL_HI:`PSW_LVL_LO];
                ien_q <= hwdata[`PSW_IEN_BIT];
            end else if (entry_ack && trap_valid && irq_entry_q) begin
                cpu_level_q <= entry_level;
            end
            if (wr_cnt) begin
                chan_count_q[wr_addr_q[4:2]] <= hwdata[7:0];
            end else if (take_chan) begin
                chan_count_q[win_chan] <= chan_count_q[win_chan] - 8'h01;
            end
            tflag_q <= (tflag_q & ~((wr_pend_q && wr_addr_q == `OFS_TRAP_FLAGS) ? hwdata[8:0] : 9'h000))
                | tset;
            if (wr_pend_q && wr_addr_q == `OFS_SW_TRAP) begin
                sw_trap_q <= 1'b1;
                sw_trap_num_q <= hwdata[6:0];
            end else if (entry_ack && trap_valid && !irq_entry_q && trap_priority == 2'h0) begin
                // Only the software trap's own entry retires it; hardware traps leave it pending.
                sw_trap_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Trap selection: reset, class A, class B, interrupt, software trap.
    // ------------------------------------------------------------------------
    reg [6:0] sel_num;
    reg [1:0] sel_prio;
    reg sel_valid;
    always @* begin
        sel_valid = 1'b1;
        sel_prio = 2'h2;
        sel_num = `TRAP_RESET;
        if (tflag_q[0]) begin
            sel_num = `TRAP_NMI;
        end else if (tflag_q[1]) begin
            sel_num = `TRAP_STACK_OVERFLOW_FLAG;
        end else if (tflag_q[2]) begin
            sel_num = `TRAP_STACK_UNDERFLOW_FLAG;
        end else if (tflag_q[3]) begin
            sel_num = `TRAP_DEBUG;
        end else if (|tflag_q[8:4]) begin
            sel_num = `TRAP_CLASS_B;
            sel_prio = `TRAP_PRIO_B;
        end else if (take_irq) begin
            sel_num = `TRAP_NODE_BASE + {3'b000, best_idx};
            sel_prio = 2'h0;
        end else if (sw_trap_q) begin
            sel_num = sw_trap_num_q;
            sel_prio = 2'h0;
        end else begin
            sel_valid = 1'b0;
        end
    end

    // Vector outputs; a reset request forces the reset vector.
    wire reset_req;
    assign reset_req = software_reset_instruction | watchdog_overflow;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_valid <= 1'b0;
            trap_number <= `TRAP_RESET;
            trap_vector <= 9'h000;
            trap_priority <= `TRAP_PRIO_RESET;
            entry_level <= 4'h0;
            irq_entry_q <= 1'b0;
            restart <= 1'b1;
            event_xfer <= 1'b0;
            event_channel <= 3'h0;
        end else begin
            restart <= reset_req;
            event_xfer <= take_chan;
            event_channel <= win_chan;
            if (reset_req) begin
                trap_valid <= 1'b1;
                trap_number <= `TRAP_RESET;
                trap_vector <= 9'h000;
                trap_priority <= `TRAP_PRIO_RESET;
                irq_entry_q <= 1'b0;
            end else if (trap_valid && entry_ack) begin
                trap_valid <= 1'b0;
            end else if (!trap_valid && sel_valid) begin
                trap_valid <= 1'b1;
                trap_number <= sel_num;
                trap_vector <= {sel_num, 2'b00};
                trap_priority <= sel_prio;
                irq_entry_q <= take_irq;
                // Software traps keep the running level.
                entry_level <= take_irq ? best_lvl : cpu_level_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read mux, registered for the data phase.
    // ------------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (haddr[11:6] == 6'h00) begin
                hrdata <= {24'h00_0000, ctl_q[haddr[5:2]]};
            end else if (haddr == `OFS_PSW) begin
                hrdata <= {16'h0000, cpu_level_q, ien_q, 11'h000};
            end else if (haddr == `OFS_TRAP_FLAGS) begin
                hrdata <= {23'h00_0000, tflag_q};
            end else if (haddr == `OFS_VECTOR) begin
                hrdata <= {23'h00_0000, trap_vector};
            end else if (haddr[11:5] == `OFS_CHAN_COUNT_BASE >> 5) begin
                hrdata <= {24'h00_0000, chan_count_q[haddr[4:2]]};
            end
        end
    end

endmodule

// File: trap_arbiter_defines.vh
// Constants of the trap and interrupt arbiter: offsets, fields, vectors and resets.
// Behaviour
// - Vector address equals trap number times four.
// - Legacy bus lines share USB and event nodes.
// - Any reset starts at vector zero, trap 00.
// - Reset outranks everything, trap priority III.
// - Software traps reach 0x000..0x1FC, numbers 00..7F.
// - Software trap keeps current CPU level.
// - Class A traps vector to 08,10,18,20.
// - Class B traps share vector 28, number 0A.
// - Pick single highest pending request each cycle.
// - Serve only if above CPU level.
// - Group level orders same-level simultaneous requests.
// - Need global enable, CPU level and source enable.
// - One control register per interrupt node.
// - Upper byte reads zero, ignores writes.
// - All control bits software readable and writable.
// - Layout: request 7, enable 6, level 5:2, group 1:0.
// - Group value 3 highest, 0 lowest.
// - Level F highest, 0 lowest.
// - Enable zero blocks, one allows request.
// - Hardware sets flag; entry or transfer clears it.
// - Flag stays set when transfer count hits zero.
// - Software flag writes act like hardware.
// - Levels 15/14 use channel unless count zero.
// - Channel number is level bit zero plus group.
`ifndef TRAP_ARBITER_DEFINES_VH
`define TRAP_ARBITER_DEFINES_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define NUM_NODES 16
`define OFS_CTRL_BASE 12'h000
`define OFS_PSW 12'h100
`define OFS_TRAP_FLAGS 12'h104
`define OFS_VECTOR 12'h108
`define OFS_SW_TRAP 12'h10C
`define OFS_CHAN_COUNT_BASE 12'h180

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define CTL_REQ_BIT 7
`define CTL_EN_BIT 6
`define CTL_LVL_HI 5
`define CTL_LVL_LO 2
`define CTL_GRP_HI 1
`define CTL_GRP_LO 0
`define CTL_RESET 8'h00
`define PSW_LVL_HI 15
`define PSW_LVL_LO 12
`define PSW_IEN_BIT 11
`define PSW_RESET 16'h0000
`define PSW_LVL_RESET 4'h0
`define CHAN_LVL_HI 4'hF
`define CHAN_LVL_LO 4'hE

// ----------------------------------------------------------------------------
// Trap numbers and vector scaling
// ----------------------------------------------------------------------------
`define VEC_SHIFT 2
`define TRAP_RESET 7'h00
`define TRAP_NMI 7'h02
`define TRAP_STACK_OVERFLOW_FLAG 7'h04
`define TRAP_STACK_UNDERFLOW_FLAG 7'h06
`define TRAP_DEBUG 7'h08
`define TRAP_CLASS_B 7'h0A
`define TRAP_NODE_BASE 7'h40
`define USB_TX_NODE 0
`define EXT_EVENT_NODE 1
`define TRAP_PRIO_RESET 2'h3
`define TRAP_PRIO_B 2'h1

`endif

// File: trap_arbiter_props.sv
// Concurrent checks on the ports of the trap and interrupt arbiter.
`timescale 1ns/100ps
module trap_arbiter_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic software_reset_instruction,
    input wire logic watchdog_overflow,
    input wire logic entry_ack,
    input wire logic trap_valid,
    input wire logic [6:0] trap_number,
    input wire logic [8:0] trap_vector,
    input wire logic [1:0] trap_priority,
    input wire logic restart
);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_reset_req;
        software_reset_instruction || watchdog_overflow;
    endsequence
    sequence s_ack;
        trap_valid && entry_ack && !(software_reset_instruction || watchdog_overflow);
    endsequence
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_vector;
        trap_valid |-> trap_vector == {trap_number, 2'b00};
    endproperty
    a_vector: assert property (p_vector) else $error("vector is not four times the trap number");
    // A pending trap must not change under the CPU while it is offered.
    property p_hold;
        trap_valid && !entry_ack && !software_reset_instruction && !watchdog_overflow
            |=> trap_valid && $stable(trap_number);
    endproperty
    a_hold: assert property (p_hold) else $error("offered trap dropped or changed before entry");
    property p_restart;
        s_reset_req |=> restart;
    endproperty
    a_restart: assert property (p_restart) else $error("reset request gave no restart");
    property p_reset_vec;
        restart |-> trap_number == 7'h00 && trap_priority == 2'h3;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("restart without reset vector at top priority");
    property p_class_a;
        trap_valid && trap_number inside {7'h02, 7'h04, 7'h06, 7'h08} |-> trap_priority == 2'h2;
    endproperty
    a_class_a: assert property (p_class_a) else $error("class A trap with wrong priority");
    property p_class_b;
        trap_valid && trap_number == 7'h0A |-> trap_priority == 2'h1;
    endproperty
    a_class_b: assert property (p_class_b) else $error("class B trap with wrong priority");
    property p_ack;
        s_ack |=> !trap_valid;
    endproperty
    a_ack: assert property (p_ack) else $error("trap still offered after entry");
    property p_low_prio;
        trap_valid && trap_number > 7'h0A |-> trap_priority == 2'h0;
    endproperty
    a_low_prio: assert property (p_low_prio) else $error("interrupt or software trap above level zero");
endmodule
